// File: advanced_general_timer_tb_top.sv
module advanced_general_timer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cnt_en, cnt32, hall_en, out_en, brake_en, brake_pol, brake_clr;
   logic dbg_halt, dbg_freeze_en, upd_clr, trig_out, brake_flag, upd_flag;
   logic [1:0] cnt_mode, slave_mode;
   logic [15:0] psc_val;
   logic [31:0] arr_val, cnt_val, v;
   logic [7:0] rep_val, dead_time;
   logic [3:0][1:0] ch_mode;
   logic [3:0][31:0] ccr_val, cap_val;
   logic [4:0] dma_en, dma_ack, dma_req;
   logic [3:0] cc_clr, cc_flag, ch_out, ch_in;
   logic [2:0] ch_out_n, hall_in;
   logic enc_a, enc_b, brake_in, trig_in, ce, one_pulse, t3;
   logic [1:0] qp = 2'h0;
   logic [1:0] h, lasth;
   int fail_count = 0;
   int check_count = 0;
   int e, n, k, g, sw, top, p, x, r, tg;

   always #25 clk = ~clk;

   agt_timer i_agt_timer (
      .clk(clk), .rst_b(rst_b), .ce(ce), .cnt_en(cnt_en),
      .cnt_mode(cnt_mode), .cnt32(cnt32), .one_pulse(one_pulse),
      .psc_val(psc_val), .arr_val(arr_val), .rep_val(rep_val),
      .slave_mode(slave_mode), .trig_in(trig_in), .trig_out(trig_out),
      .ch_mode(ch_mode), .ccr_val(ccr_val), .ch_in(ch_in),
      .hall_in(hall_in), .hall_en(hall_en), .enc_a(enc_a), .enc_b(enc_b),
      .dead_time(dead_time), .out_en(out_en), .brake_in(brake_in),
      .brake_en(brake_en), .brake_pol(brake_pol), .brake_clr(brake_clr),
      .brake_flag(brake_flag), .dbg_halt(dbg_halt),
      .dbg_freeze_en(dbg_freeze_en), .dma_en(dma_en), .dma_ack(dma_ack),
      .dma_req(dma_req), .upd_clr(upd_clr), .upd_flag(upd_flag),
      .cc_clr(cc_clr), .cc_flag(cc_flag), .cap_val(cap_val),
      .cnt_val(cnt_val), .ch_out(ch_out), .ch_out_n(ch_out_n)
   );

   agt_partner i_agt_partner (
      .clk(clk), .enc_a(enc_a), .enc_b(enc_b), .hall_in(hall_in),
      .ch_in(ch_in), .brake_in(brake_in), .trig_in(trig_in)
   );

   ///////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask

   task automatic done(input string s);
      $display("%s finished", s);
   endtask

   // Cycles between update events: repetitions times periods times prescale
   function automatic int upd_span(input int rp, input int ar, input int ps);
      return (rp + 1) * (ar + 1) * (ps + 1);
   endfunction

   // Reset for twelve cycles, then start counting on release
   task automatic start(input logic [1:0] m, input logic [31:0] a,
         input logic w, input logic [15:0] ps, input logic [7:0] rp);
      rst_b = 1'b0;
      cnt_en = 1'b0;
      {cnt_mode, arr_val, cnt32, psc_val, rep_val} = {m, a, w, ps, rp};
      cyc(12);
      chk(cnt_val | {ch_out_n, ch_out, cc_flag, dma_req, upd_flag, trig_out,
         brake_flag}, 32'h0);
      rst_b = 1'b1;
      cnt_en = 1'b1;
   endtask

   // Count expected from the quadrant walk: A edges only, up when A differs from B
   task automatic enc(input logic fwd);
      logic [1:0] np;
      np = fwd ? qp + 2'h1 : qp - 2'h1;
      if ((^np) != (^qp)) e = ((^np) != np[1]) ? e + 1 : e - 1;
      qp = np;
      i_agt_partner.step(fwd);
   endtask

   // Span reckoned from the tests, at most about 1,000 cycles, with wide margin
   initial begin
      #(5000 * 50);
      fail_count++;
      tally_and_finish();
   end

   ///////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(71280));
      {cnt_en, cnt32, hall_en, out_en, brake_en, brake_pol, brake_clr} = '0;
      {dbg_halt, dbg_freeze_en, upd_clr, cnt_mode, slave_mode, psc_val} = '0;
      {arr_val, rep_val, dead_time, ch_mode, ccr_val, dma_en, dma_ack} = '0;
      cc_clr = 4'h0;
      {ce, one_pulse} = 2'b10;
      for (int m = 0; m < 3; m++) begin
         top = $urandom_range(9, 2);
         g = $urandom_range(1, 0);
         start(m[1:0], g ? top : 32'h10000 | top, g[0], 16'h0, 8'h0);
         n = 0;
         while (cnt_val === 32'h0 && n < 20) begin
            cyc(1);
            n++;
         end
         e = (m == 1) ? top : 1;
         chk(cnt_val, e);
         k = 1;
         repeat (3 * top + 4) begin
            cyc(1);
            if (m == 2 && e == top) k = 0;
            if (m == 2 && e == 0) k = 1;
            if (m == 1 || (m == 2 && k == 0)) e = (e == 0) ? top : e - 1;
            else e = (e == top) ? 0 : e + 1;
            chk(cnt_val, e);
         end
         done("count mode");
      end
      p = $urandom_range(3, 0);
      x = $urandom_range(6, 3);
      r = $urandom_range(3, 0);
      dma_en = 5'h10;
      start(2'h0, x, 1'b0, p[15:0], r[7:0]);
      n = 0;
      k = 0;
      while (k < 4 && n < 600) begin
         cyc(1);
         n++;
         if (trig_out === 1'b1) begin
            if (k > 0) chk(n, upd_span(r, x, p));
            k++;
            n = 0;
         end
      end
      chk(k, 4);
      chk({upd_flag, dma_req[4]}, 2'b11);
      upd_clr = 1'b1;
      dma_ack = 5'h10;
      cyc(1);
      {upd_clr, dma_ack} = '0;
      chk({trig_out, upd_flag, dma_req[4]}, 3'b000);
      done("update");
      // Channel 3 is off, so its pulse must be ignored
      ch_mode = {2'b11, 2'b00, 2'b11, 2'b00};
      dma_en = 5'h04;
      start(2'h3, 32'hFFFFFFFF, 1'b1, 16'h0, 8'h0);
      e = 0;
      n = $urandom_range(12, 4);
      repeat (n) enc(1'b1);
      repeat ($urandom_range(n, 0)) enc(1'b0);
      cyc(3);
      chk(cnt_val, e);
      i_agt_partner.pulse(2);
      i_agt_partner.pulse(3);
      chk(cap_val[2], e);
      chk({cc_flag, dma_req[3:0]}, 8'h44);
      cc_clr = 4'hF;
      cyc(1);
      cc_clr = 4'h0;
      hall_en = 1'b1;
      enc(1'b1);
      enc(1'b1);
      i_agt_partner.hall();
      cyc(2);
      chk(cap_val[0], e);
      chk(cc_flag, 4'h1);
      {hall_en, dma_en} = '0;
      done("capture");
      slave_mode = 2'h1;
      start(2'h0, 32'hFFFF, 1'b0, 16'h0, 8'h0);
      cyc(40);
      chk(cnt_val > 32'h1E, 1'b1);
      i_agt_partner.trig();
      chk(cnt_val < 32'h8, 1'b1);
      slave_mode = 2'h2;
      cyc(4);
      v = cnt_val;
      cyc(10);
      chk(cnt_val, v);
      // One pulse stops at the first update; a trigger edge or a new rise of cnt_en restarts it
      slave_mode = 2'h3;
      one_pulse = 1'b1;
      start(2'h0, 32'h9, 1'b0, 16'h0, 8'h0);
      cyc(20);
      chk(upd_flag, 1'b1);
      chk(cnt_val, 32'h0);
      i_agt_partner.trig();
      chk(cnt_val, 32'h3);
      {slave_mode, one_pulse} = '0;
      done("chain");
      // Channel 3 toggles once per counter period
      ch_mode = {2'b01, 2'b10, 2'b10, 2'b10};
      ccr_val = {32'h0, 32'h5, 32'hF, 32'hA};
      g = $urandom_range(4, 1);
      dead_time = g[7:0];
      out_en = 1'b1;
      start(2'h0, 32'h13, 1'b0, 16'h0, 8'h0);
      sw = 0;
      n = 0;
      lasth = 2'b00;
      tg = 0;
      t3 = 1'b0;
      repeat (200) begin
         cyc(1);
         tg += (ch_out[3] != t3);
         t3 = ch_out[3];
         h = {ch_out_n[0], ch_out[0]};
         chk(ch_out[2:0] & ch_out_n, 3'h0);
         if (h == 2'b00) n++;
         else begin
            if (lasth != 2'b00 && h != lasth) begin
               chk(n >= g + 1, 1'b1);
               sw++;
            end
            lasth = h;
            n = 0;
         end
      end
      chk(sw > 10, 1'b1);
      chk(tg inside {[9:10]}, 1'b1);
      {brake_pol, brake_en} = 2'b11;
      i_agt_partner.brake(1'b1);
      cyc(2);
      chk({brake_flag, ch_out, ch_out_n}, 8'h80);
      i_agt_partner.brake(1'b0);
      chk(brake_flag, 1'b1);
      brake_clr = 1'b1;
      cyc(1);
      brake_clr = 1'b0;
      cyc(4);
      chk(brake_flag, 1'b0);
      {dbg_halt, dbg_freeze_en} = 2'b11;
      cyc(3);
      v = cnt_val;
      cyc(10);
      chk(cnt_val, v);
      chk({ch_out, ch_out_n}, 7'h0);
      {dbg_halt, dbg_freeze_en} = 2'b00;
      cyc(3);
      chk(cnt_val != v, 1'b1);
      // Clock enable low holds every register, counter included
      ce = 1'b0;
      v = cnt_val;
      cyc(6);
      chk(cnt_val, v);
      ce = 1'b1;
      done("pwm");
      tally_and_finish();
   end
endmodule

// File: agt_dead_time.sv
module agt_dead_time (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic ref_in,
   input wire logic [7:0] dead_time,
   output logic out_p,
   output logic out_n
);

   logic ref_prev_reg;
   logic [7:0] dt_cnt_reg;
   logic settle;

   // Both legs stay off until the reference has been stable for the dead time
   assign settle = (ref_in == ref_prev_reg) && (dt_cnt_reg == agt_pkg::DT_RST);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_prev_reg <= 1'b0;
         dt_cnt_reg <= agt_pkg::DT_RST;
      end else if (ce) begin
         ref_prev_reg <= ref_in;
         if (ref_in != ref_prev_reg) begin
            dt_cnt_reg <= dead_time;
         end else if (dt_cnt_reg != agt_pkg::DT_RST) begin
            dt_cnt_reg <= dt_cnt_reg - 8'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_p <= 1'b0;
         out_n <= 1'b0;
      end else if (ce) begin
         out_p <= settle & ref_in;
         out_n <= settle & ~ref_in;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_DT_EXCL: assert property (!(out_p && out_n))
      else $error("Both legs of a complementary pair are on");
   AST_DT_GAP: assert property (ce && (ref_in != ref_prev_reg) |=> !out_p && !out_n)
      else $error("No dead time after a reference edge");

endmodule

// File: agt_partner.sv
module agt_partner (
   input wire logic clk,
   output logic enc_a,
   output logic enc_b,
   output logic [2:0] hall_in,
   output logic [3:0] ch_in,
   output logic brake_in,
   output logic trig_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [1:0] pos = 2'h0;

   initial begin
      {enc_a, enc_b, hall_in, ch_in, brake_in, trig_in} = '0;
   end

   ///////////////////////////////////////////////////////////////
   // Every level is held three cycles, longer than the pin filter
   task automatic hold();
      repeat (3) @(negedge clk);
   endtask

   // Gray quadrant step; A leads B when turning forward
   task automatic step(input logic fwd);
      pos = fwd ? pos + 2'h1 : pos - 2'h1;
      enc_a = ^pos;
      enc_b = pos[1];
      hold();
   endtask

   // Hall sensors walk a rotation, one bit changing at a time
   task automatic hall();
      hall_in = {hall_in[1:0], ~hall_in[2]};
      hold();
   endtask

   task automatic pulse(input int i);
      ch_in[i] = 1'b1;
      hold();
      ch_in[i] = 1'b0;
      hold();
   endtask

   task automatic trig();
      trig_in = 1'b1;
      hold();
      trig_in = 1'b0;
      hold();
   endtask

   task automatic brake(input logic lvl);
      brake_in = lvl;
      hold();
   endtask
endmodule

// File: agt_pkg.sv
package agt_pkg;

   // Positions in the synchronised pin vector
   localparam int SYNC_W = 11;
   localparam int IN_CH_LSB = 0;
   localparam int IN_HALL_LSB = 4;
   localparam int IN_ENC_A = 7;
   localparam int IN_ENC_B = 8;
   localparam int IN_BRAKE = 9;
   localparam int IN_TRIG = 10;

   // Counter width masks and reset values
   localparam logic [31:0] MASK16 = 32'h0000FFFF;
   localparam logic [31:0] MASK32 = 32'hFFFFFFFF;
   localparam logic [31:0] CNT_RST = 32'h00000000;
   localparam logic [15:0] PSC_RST = 16'h0000;
   localparam logic [7:0] REP_RST = 8'h00;
   localparam logic [7:0] DT_RST = 8'h00;
   localparam int DMA_UPD = 4;

   typedef enum logic [1:0] {
      CNT_UP = 2'b00,
      CNT_DOWN = 2'b01,
      CNT_CENTER = 2'b10,
      CNT_ENCODER = 2'b11
   } agt_cnt_mode_t;

   typedef enum logic [1:0] {
      SLV_NONE = 2'b00,
      SLV_RESET = 2'b01,
      SLV_GATED = 2'b10,
      SLV_TRIGGER = 2'b11
   } agt_slave_t;

   typedef enum logic [1:0] {
      CH_CAPTURE = 2'b00,
      CH_TOGGLE = 2'b01,
      CH_PWM = 2'b10,
      CH_OFF = 2'b11
   } agt_ch_mode_t;

endpackage

// File: agt_timer.sv
// How it works
// - The advanced timer counts 16 bits up, down or up/down with auto-reload through a 16-bit prescaler.
// - A general timer counts up/down with auto-reload at 16 or 32 bits through a 16-bit prescaler.
// - Three channels drive complementary pairs with programmable dead time between edges.
// - The update event is raised at the first period end, then once every rep_val + 1 counter periods.
// - An active brake forces every PWM output to the safe low state.
// - Four channels each work as input capture, output compare, PWM or one-pulse output.
// - Timers chain through a trigger input and an update trigger output for sync or events.
// - While the core is halted in debug the counter may freeze and the PWM outputs turn off.
// - Each timer has its own DMA requests for channel and update events.
// - In encoder mode the counter follows the phase relation of two quadrature inputs.
// - Up to three Hall sensor inputs are combined into a capture trigger.
module agt_timer (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic cnt_en,
   input wire logic [1:0] cnt_mode,
   input wire logic cnt32,
   input wire logic one_pulse,
   input wire logic [15:0] psc_val,
   input wire logic [31:0] arr_val,
   input wire logic [7:0] rep_val,
   input wire logic [1:0] slave_mode,
   input wire logic trig_in,
   output logic trig_out,
   input wire logic [3:0][1:0] ch_mode,
   input wire logic [3:0][31:0] ccr_val,
   input wire logic [3:0] ch_in,
   input wire logic [2:0] hall_in,
   input wire logic hall_en,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic [7:0] dead_time,
   input wire logic out_en,
   input wire logic brake_in,
   input wire logic brake_en,
   input wire logic brake_pol,
   input wire logic brake_clr,
   output logic brake_flag,
   input wire logic dbg_halt,
   input wire logic dbg_freeze_en,
   input wire logic [4:0] dma_en,
   input wire logic [4:0] dma_ack,
   output logic [4:0] dma_req,
   input wire logic upd_clr,
   output logic upd_flag,
   input wire logic [3:0] cc_clr,
   output logic [3:0] cc_flag,
   output logic [3:0][31:0] cap_val,
   output logic [31:0] cnt_val,
   output logic [3:0] ch_out,
   output logic [2:0] ch_out_n
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [agt_pkg::SYNC_W-1:0] pin_raw;
   logic [agt_pkg::SYNC_W-1:0] meta_reg;
   logic [agt_pkg::SYNC_W-1:0] sync_reg;
   logic [agt_pkg::SYNC_W-1:0] prev_reg;
   logic [agt_pkg::SYNC_W-1:0] rise;
   logic hall_chg;
   logic enc_edge;
   logic enc_up;
   logic trig_rise;

   assign pin_raw = {trig_in, brake_in, enc_b, enc_a, hall_in, ch_in};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else if (ce) begin
         meta_reg <= pin_raw;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign rise = sync_reg & ~prev_reg;
   assign trig_rise = rise[agt_pkg::IN_TRIG];
   // Any Hall line changing marks a new rotor sector
   assign hall_chg = |(sync_reg[agt_pkg::IN_HALL_LSB +: 3] ^ prev_reg[agt_pkg::IN_HALL_LSB +: 3]);
   // Counts on both edges of A, so resolution is twice the line count
   assign enc_edge = sync_reg[agt_pkg::IN_ENC_A] ^ prev_reg[agt_pkg::IN_ENC_A];
   assign enc_up = sync_reg[agt_pkg::IN_ENC_A] ^ sync_reg[agt_pkg::IN_ENC_B];

   ////////////////////////////////////////////////////////////////////////////////
   // Run control, prescaler and gating
   logic frozen;
   logic run_reg;
   logic en_prev_reg;
   logic count_ok;
   logic tick;
   logic [15:0] psc_cnt_reg;
   logic [31:0] mask;
   logic [31:0] top;
   logic period_end;
   logic upd_evt;
   logic slv_reset;

   assign frozen = dbg_halt & dbg_freeze_en;
   assign mask = cnt32 ? agt_pkg::MASK32 : agt_pkg::MASK16;
   assign top = arr_val & mask;
   assign count_ok = run_reg & ~frozen
      & ((slave_mode != agt_pkg::SLV_GATED) | sync_reg[agt_pkg::IN_TRIG]);
   assign slv_reset = (slave_mode == agt_pkg::SLV_RESET) & trig_rise & ~frozen;
   assign tick = count_ok & ((cnt_mode == agt_pkg::CNT_ENCODER) ? enc_edge
      : (psc_cnt_reg == psc_val));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         psc_cnt_reg <= agt_pkg::PSC_RST;
      end else if (ce && count_ok) begin
         psc_cnt_reg <= (psc_cnt_reg == psc_val) ? agt_pkg::PSC_RST
            : psc_cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_reg <= 1'b0;
         en_prev_reg <= 1'b0;
      end else if (ce) begin
         en_prev_reg <= cnt_en;
         if ((cnt_en && !en_prev_reg) || (cnt_en && slave_mode == agt_pkg::SLV_TRIGGER
               && trig_rise)) begin
            run_reg <= 1'b1;
         end else if (!cnt_en || (one_pulse && upd_evt)) begin
            run_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic dir_reg;
   logic dir_next;
   logic cnt_moved_reg;

   always_comb begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      period_end = 1'b0;
      if (slv_reset) begin
         cnt_next = (cnt_mode == agt_pkg::CNT_DOWN) ? top : agt_pkg::CNT_RST;
      end else if (tick) begin
         case (cnt_mode)
            agt_pkg::CNT_UP: begin
               period_end = (cnt_reg >= top);
               cnt_next = period_end ? agt_pkg::CNT_RST : cnt_reg + 32'h1;
            end
            agt_pkg::CNT_DOWN: begin
               period_end = (cnt_reg == agt_pkg::CNT_RST);
               cnt_next = period_end ? top : cnt_reg - 32'h1;
            end
            agt_pkg::CNT_CENTER: begin
               // Events at both turning points, as a centre-aligned PWM needs
               if (!dir_reg) begin
                  period_end = (cnt_reg >= top);
                  dir_next = period_end;
                  cnt_next = period_end ? top - 32'h1 : cnt_reg + 32'h1;
               end else begin
                  period_end = (cnt_reg == agt_pkg::CNT_RST);
                  dir_next = ~period_end;
                  cnt_next = period_end ? 32'h1 : cnt_reg - 32'h1;
               end
            end
            agt_pkg::CNT_ENCODER: begin
               if (enc_up) begin
                  period_end = (cnt_reg >= top);
                  cnt_next = period_end ? agt_pkg::CNT_RST : cnt_reg + 32'h1;
               end else begin
                  period_end = (cnt_reg == agt_pkg::CNT_RST);
                  cnt_next = period_end ? top : cnt_reg - 32'h1;
               end
            end
            default: begin
               cnt_next = cnt_reg;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= agt_pkg::CNT_RST;
         dir_reg <= 1'b0;
         cnt_moved_reg <= 1'b0;
      end else if (ce) begin
         cnt_reg <= cnt_next & mask;
         dir_reg <= dir_next;
         cnt_moved_reg <= tick | slv_reset;
      end
   end

   assign cnt_val = cnt_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Repetition and update event
   logic [7:0] rep_cnt_reg;

   assign upd_evt = period_end & (rep_cnt_reg == agt_pkg::REP_RST);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rep_cnt_reg <= agt_pkg::REP_RST;
      end else if (ce && period_end) begin
         rep_cnt_reg <= upd_evt ? rep_val : rep_cnt_reg - 8'h01;
      end
   end

   // Set wins over a clear in the same cycle so no update is lost
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         upd_flag <= 1'b0;
         trig_out <= 1'b0;
      end else if (ce) begin
         trig_out <= upd_evt;
         if (upd_evt) begin
            upd_flag <= 1'b1;
         end else if (upd_clr) begin
            upd_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channels
   logic [3:0] cc_evt;
   logic [3:0] dt_p;
   logic [2:0] dt_n;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_ch
         logic ref_reg;
         logic flag_reg;
         logic [31:0] cap_reg;
         logic match;
         logic cap_evt;
         logic [31:0] ccr_eff;

         assign ccr_eff = ccr_val[gi] & mask;
         assign match = cnt_moved_reg & (cnt_reg == ccr_eff);
         if (gi == 0) begin : g_hall
            assign cap_evt = (ch_mode[gi] == agt_pkg::CH_CAPTURE)
               & (hall_en ? hall_chg : rise[agt_pkg::IN_CH_LSB + gi]);
         end else begin : g_pin
            assign cap_evt = (ch_mode[gi] == agt_pkg::CH_CAPTURE)
               & rise[agt_pkg::IN_CH_LSB + gi];
         end
         assign cc_evt[gi] = cap_evt | (match & (ch_mode[gi] == agt_pkg::CH_TOGGLE
            || ch_mode[gi] == agt_pkg::CH_PWM));

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               ref_reg <= 1'b0;
            end else if (ce) begin
               case (ch_mode[gi])
                  agt_pkg::CH_TOGGLE: ref_reg <= ref_reg ^ match;
                  agt_pkg::CH_PWM: ref_reg <= run_reg & (cnt_reg < ccr_eff);
                  default: ref_reg <= 1'b0;
               endcase
            end
         end

         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               cap_reg <= agt_pkg::CNT_RST;
               flag_reg <= 1'b0;
            end else if (ce) begin
               if (cap_evt) begin
                  cap_reg <= cnt_reg;
               end
               if (cc_evt[gi]) begin
                  flag_reg <= 1'b1;
               end else if (cc_clr[gi]) begin
                  flag_reg <= 1'b0;
               end
            end
         end

         assign cc_flag[gi] = flag_reg;
         assign cap_val[gi] = cap_reg;

         if (gi < 3) begin : g_dt
            agt_dead_time u_dt (
               .clk(clk),
               .rst_b(rst_b),
               .ce(ce),
               .ref_in(ref_reg),
               .dead_time(dead_time),
               .out_p(dt_p[gi]),
               .out_n(dt_n[gi])
            );
         end else begin : g_single
            assign dt_p[gi] = ref_reg;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // DMA requests, held until acknowledged; a new event beats the ack
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_req <= 5'h00;
      end else if (ce) begin
         dma_req <= (dma_req & ~dma_ack) | (dma_en & {upd_evt, cc_evt});
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Brake and output stage
   logic brake_hit;
   logic safe;

   assign brake_hit = brake_en & (sync_reg[agt_pkg::IN_BRAKE] == brake_pol);
   // Latched so a glitch on the brake line cannot re-enable the bridge by itself
   assign safe = brake_flag | frozen | ~out_en;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         brake_flag <= 1'b0;
      end else if (ce) begin
         if (brake_hit) begin
            brake_flag <= 1'b1;
         end else if (brake_clr) begin
            brake_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ch_out <= 4'h0;
         ch_out_n <= 3'h0;
      end else if (ce) begin
         ch_out <= safe ? 4'h0 : dt_p;
         ch_out_n <= safe ? 3'h0 : dt_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_UP_STEP: assert property (ce && tick && !slv_reset && cnt_mode == agt_pkg::CNT_UP
         && cnt_reg < top |=> cnt_reg == (($past(cnt_reg) + 32'h1) & $past(mask)))
      else $error("Up count did not advance by one");
   AST_WIDTH16: assert property (ce && !cnt32 |=> cnt_reg[31:16] == 16'h0000)
      else $error("Counter exceeds 16 bits in 16-bit mode");
   AST_REP: assert property (ce && upd_evt |=> rep_cnt_reg == $past(rep_val))
      else $error("Repetition count not reloaded on update");
   AST_BRAKE: assert property (ce && brake_flag |=> ch_out == 4'h0 && ch_out_n == 3'h0)
      else $error("Outputs active during brake");
   AST_CHAIN: assert property (ce |=> trig_out == $past(upd_evt))
      else $error("Trigger output does not follow the update event");
   AST_FREEZE: assert property (ce && frozen |=> cnt_reg == $past(cnt_reg) && ch_out == 4'h0)
      else $error("Counter moved or outputs on while frozen");
   AST_DMA_UPD: assert property (ce && upd_evt && dma_en[agt_pkg::DMA_UPD]
         |=> dma_req[agt_pkg::DMA_UPD])
      else $error("Update DMA request not raised");
   AST_ENC: assert property (ce && tick && !slv_reset && cnt_mode == agt_pkg::CNT_ENCODER
         && !enc_up && cnt_reg != 32'h0 |=> cnt_reg == $past(cnt_reg) - 32'h1)
      else $error("Encoder did not count down");
   AST_HALL: assert property (ce && hall_en && hall_chg
         && ch_mode[0] == agt_pkg::CH_CAPTURE |=> cc_flag[0])
      else $error("Hall change did not capture");
   AST_UPD_FLAG: assert property (ce && upd_evt |=> upd_flag)
      else $error("Update flag not set");
   AST_RELOAD: assert property (ce && tick && !slv_reset && cnt_mode == agt_pkg::CNT_DOWN
         && cnt_reg == 32'h0 |=> cnt_reg == $past(top))
      else $error("Down counter did not reload");
   AST_CAPTURE: assert property (ce && g_ch[2].cap_evt
         |=> cap_val[2] == $past(cnt_reg) && cc_flag[2])
      else $error("Capture value or flag wrong");

   COV_UPDATE: cover property (ce && upd_evt ##1 upd_flag);
   COV_CAPTURE: cover property (ce && g_ch[2].cap_evt);
   COV_BRAKE: cover property (ce && brake_hit ##1 brake_flag);
   COV_ENC_DOWN: cover property (ce && tick && cnt_mode == agt_pkg::CNT_ENCODER && !enc_up);

endmodule
